/* core/frame_queue_consts.vh */
// register offsets, field positions, policy codes and sizes of the frame queue
// included by the frame queue design; definitions only
`ifndef FRAME_QUEUE_CONSTS_VH
`define FRAME_QUEUE_CONSTS_VH
// printed register offsets (register indices, AXI address = 4 * index)
`define OFS_ACC_FIRST      6'h02
`define OFS_ACC_LAST       6'h07
`define OFS_IRQ_STATUS_B   6'h0A
`define OFS_RO_LAST        6'h0E
`define OFS_QUEUE_LEVEL    6'h0E
`define OFS_SOFT_RESTART   6'h14
`define OFS_IRQ_ENABLE_B   6'h17
`define OFS_IRQ_PIN_MAP_B  6'h1A
`define OFS_IRQ_LATCH      6'h21
`define OFS_QUEUE_THRESH   6'h30
`define OFS_QUEUE_CONFIG   6'h3E
`define OFS_QUEUE_DATA     6'h3F
// field positions
`define POLICY_LSB         6
`define AXIS_LSB           0
`define BIT_THR_EVENT      6
`define BIT_FULL_EVENT     5
`define BIT_OVERRUN        7
`define LEVEL_MSB          6
`define THR_MSB            5
// policy and axis encodings
`define POLICY_SINGLE      2'h0
`define POLICY_STOP        2'h1
`define POLICY_OVERWRITE   2'h2
`define AXIS_ALL           2'h0
`define AXIS_X             2'h1
`define AXIS_Y             2'h2
`define AXIS_Z             2'h3
// depths, last byte indices and restart key
`define DEPTH_STOP         7'h20
`define DEPTH_OVERWRITE    7'h1F
`define DEPTH_SINGLE       7'h01
`define LAST_BYTE_ALL      3'h5
`define LAST_BYTE_ONE      3'h1
`define SOFT_RESTART_KEY   8'hB6
// bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

/* core/accel_frame_queue.v */
// frame queue of an accelerometer: 32-frame buffer with AXI4-Lite register slave
// assumes sample_valid pulses one cycle per new x/y/z sample set on clk_sys
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "frame_queue_consts.vh"

// Summary of operation
// - buffer holds up to 32 frames of three 16-bit axis words.
// - stop-when-full stores to 32 frames, then drops further samples.
// - overwrite-oldest uses depth 31 and drops oldest frame when full.
// - single-frame acts as overwrite-oldest with depth one.
// - policy codes 00 single, 01 stop, 10 overwrite; reads show active policy.
// - writes to config or threshold empty queue and clear flags and events.
// - stored frames equal the acceleration result registers 0x02..0x07.
// - queue data at queue_data_port; reads there pop bytes in sequence.
// - axis field 00 all, 01 x, 10 y, 11 z; depth unchanged.
// - a partial frame read discards the rest; next read starts new frame.
// - data reads beyond the fill level return zero.
// - level field at queue_level_status shows the frames held.
// - overrun flag sets when a frame arrives into a full buffer.
// - overrun stays set when reads drain; only a config or threshold write clears it.
// - threshold event when level reaches programmed count, in every policy.
// - threshold event gated by enable irq_enable_b, mapped by irq_pin_map_b, status at irq_status_b.
// - full event after 32, 31 or 1 samples depending on policy.
// - full event needs enable at irq_enable_b and map at irq_pin_map_b; status at irq_status_b.
// - 64 byte registers; reserved bits ignore writes.
// - 0x00..queue_level_status read-only; irq_latch_control ignores writes, 0x14 restart write-only; both read 0.
module accel_frame_queue (
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire        clk_en,
   input  wire        sample_valid,
   input  wire [15:0] accel_x,
   input  wire [15:0] accel_y,
   input  wire [15:0] accel_z,
   input  wire        frame_gap,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire        second_irq_pin,
   output reg         soft_restart_pulse
);
   // frame memory, 32 entries of x/y/z
   reg  [47:0] mem [0:31];
   reg  [4:0]  wr_ptr_reg;
   reg  [4:0]  rd_ptr_reg;
   reg  [6:0]  level_reg;
   reg  [2:0]  byte_idx_reg;
   reg         overrun_reg;
   reg         full_evt_reg;
   reg         thr_evt_reg;
   reg  [1:0]  policy_reg;
   reg  [1:0]  axis_reg;
   reg  [5:0]  thresh_reg;
   reg  [7:0]  irq_en_reg;
   reg  [7:0]  irq_map_reg;
   reg  [47:0] latest_reg;
   // frame_gap from the serial link side is synchronised
   reg         gap_s1_reg;
   reg         gap_s2_reg;
   reg         aw_hold_reg;
   reg         w_hold_reg;
   reg  [5:0]  aw_idx_reg;
   reg  [7:0]  w_data_reg;

   wire [6:0]  depth;
   wire        is_full;
   wire        wr_fire;
   wire        rd_fire;
   wire        clr_queue;
   wire [5:0]  ar_idx;
   wire        data_read;
   wire        has_data;
   wire        push;
   wire        drop_old;
   wire        last_byte;
   wire        pop;
   wire [47:0] head;
   wire        gap_discard;
   wire        level_up;
   wire        level_down;
   reg  [15:0] axis_word;
   reg  [7:0]  data_byte;
   reg  [7:0]  rd_byte;

   assign depth = (policy_reg == `POLICY_STOP) ? `DEPTH_STOP :
                  (policy_reg == `POLICY_OVERWRITE) ? `DEPTH_OVERWRITE :
                  `DEPTH_SINGLE;
   assign is_full = (level_reg >= depth);

   // write address and data accepted in either order, response after both
   assign s_axi_awready = clk_en & ~aw_hold_reg & ~s_axi_bvalid;
   assign s_axi_wready  = clk_en & ~w_hold_reg & ~s_axi_bvalid;
   assign wr_fire = clk_en & aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
   assign s_axi_arready = clk_en & ~s_axi_rvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign ar_idx = s_axi_araddr[7:2];

   assign clr_queue = wr_fire & ((aw_idx_reg == `OFS_QUEUE_CONFIG) |
                                 (aw_idx_reg == `OFS_QUEUE_THRESH));
   assign data_read = rd_fire & (ar_idx == `OFS_QUEUE_DATA);
   assign has_data  = (level_reg != 7'h00);
   assign last_byte = (axis_reg == `AXIS_ALL) ? (byte_idx_reg == `LAST_BYTE_ALL) :
                      (byte_idx_reg == `LAST_BYTE_ONE);
   assign pop  = data_read & has_data & last_byte;
   assign push = clk_en & sample_valid & ~clr_queue &
                 (~is_full | (policy_reg != `POLICY_STOP));
   assign drop_old = push & is_full & ~pop;
   // a partial frame left behind at the end of an access is skipped like a pop
   assign gap_discard = gap_s2_reg & (byte_idx_reg != 3'h0) & has_data &
                        ~data_read & ~drop_old;
   // a push into a full buffer only counts when a pop frees a slot
   assign level_up   = push & (~is_full | pop);
   assign level_down = pop | gap_discard;
   assign head = mem[rd_ptr_reg];

   // single-axis capture: the stored word of the selected axis is read out
   always @* begin
      axis_word = head[15:0];
      case (axis_reg)
         `AXIS_Y: axis_word = head[31:16];
         `AXIS_Z: axis_word = head[47:32];
         default: axis_word = head[15:0];
      endcase
   end

   // byte order: x low, x high, y low, y high, z low, z high
   always @* begin
      data_byte = 8'h00;
      if (axis_reg == `AXIS_ALL) begin
         case (byte_idx_reg)
            3'h0: data_byte = head[7:0];
            3'h1: data_byte = head[15:8];
            3'h2: data_byte = head[23:16];
            3'h3: data_byte = head[31:24];
            3'h4: data_byte = head[39:32];
            3'h5: data_byte = head[47:40];
            default: data_byte = 8'h00;
         endcase
      end else begin
         data_byte = byte_idx_reg[0] ? axis_word[15:8] : axis_word[7:0];
      end
      if (!has_data) begin
         data_byte = 8'h00;
      end
   end

   always @* begin
      rd_byte = 8'h00;
      if (ar_idx == `OFS_QUEUE_DATA) begin
         rd_byte = data_byte;
      end else if (ar_idx >= `OFS_ACC_FIRST && ar_idx <= `OFS_ACC_LAST) begin
         case (ar_idx)
            6'h02: rd_byte = latest_reg[7:0];
            6'h03: rd_byte = latest_reg[15:8];
            6'h04: rd_byte = latest_reg[23:16];
            6'h05: rd_byte = latest_reg[31:24];
            6'h06: rd_byte = latest_reg[39:32];
            default: rd_byte = latest_reg[47:40];
         endcase
      end else begin
         case (ar_idx)
            `OFS_IRQ_STATUS_B: rd_byte = {1'b0, thr_evt_reg, full_evt_reg, 5'h00};
            `OFS_QUEUE_LEVEL:  rd_byte = {overrun_reg, level_reg};
            `OFS_IRQ_ENABLE_B: rd_byte = irq_en_reg;
            `OFS_IRQ_PIN_MAP_B: rd_byte = irq_map_reg;
            `OFS_QUEUE_THRESH: rd_byte = {2'h0, thresh_reg};
            `OFS_QUEUE_CONFIG: rd_byte = {policy_reg, 4'h0, axis_reg};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   assign second_irq_pin =
      (thr_evt_reg & irq_en_reg[`BIT_THR_EVENT] & irq_map_reg[`BIT_THR_EVENT]) |
      (full_evt_reg & irq_en_reg[`BIT_FULL_EVENT] & irq_map_reg[`BIT_FULL_EVENT]);

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         gap_s1_reg <= 1'b0;
         gap_s2_reg <= 1'b0;
      end else if (clk_en) begin
         gap_s1_reg <= frame_gap;
         gap_s2_reg <= gap_s1_reg;
      end
   end

   // bus slave
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aw_hold_reg  <= 1'b0;
         w_hold_reg   <= 1'b0;
         aw_idx_reg   <= 6'h00;
         w_data_reg   <= 8'h00;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
         irq_en_reg   <= 8'h00;
         irq_map_reg  <= 8'h00;
         policy_reg   <= `POLICY_SINGLE;
         axis_reg     <= `AXIS_ALL;
         thresh_reg   <= 6'h00;
         soft_restart_pulse <= 1'b0;
      end else if (clk_en) begin
         soft_restart_pulse <= 1'b0;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[7:2];
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
         if (wr_fire) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr[31:8] == 24'h000000) ?
                            `RESP_OKAY : `RESP_OKAY;
            if (aw_idx_reg > `OFS_RO_LAST) begin
               case (aw_idx_reg)
                  `OFS_IRQ_ENABLE_B:  irq_en_reg  <= w_data_reg;
                  `OFS_IRQ_PIN_MAP_B: irq_map_reg <= w_data_reg;
                  `OFS_QUEUE_THRESH:  thresh_reg  <= w_data_reg[`THR_MSB:0];
                  `OFS_QUEUE_CONFIG: begin
                     if (w_data_reg[7:6] != 2'h3) begin
                        policy_reg <= w_data_reg[7:6];
                     end
                     axis_reg <= w_data_reg[1:0];
                  end
                  `OFS_SOFT_RESTART: begin
                     soft_restart_pulse <= (w_data_reg == `SOFT_RESTART_KEY);
                  end
                  default: begin
                  end
               endcase
            end
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_rdata  <= {24'h000000, rd_byte};
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // latest sample set, also readable at the result offsets
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         latest_reg <= 48'h0;
      end else if (clk_en & sample_valid) begin
         latest_reg <= {accel_z, accel_y, accel_x};
      end
   end

   // queue pointers
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= 5'h00;
         rd_ptr_reg <= 5'h00;
      end else if (clk_en) begin
         if (clr_queue) begin
            wr_ptr_reg <= 5'h00;
            rd_ptr_reg <= 5'h00;
         end else begin
            if (push) begin
               wr_ptr_reg <= wr_ptr_reg + 5'h01;
            end
            if (pop | drop_old | gap_discard) begin
               rd_ptr_reg <= rd_ptr_reg + 5'h01;
            end
         end
      end
   end

   // fill level
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         level_reg <= 7'h00;
      end else if (clk_en) begin
         if (clr_queue) begin
            level_reg <= 7'h00;
         end else if (level_up & ~level_down) begin
            level_reg <= level_reg + 7'h01;
         end else if (level_down & ~level_up) begin
            level_reg <= level_reg - 7'h01;
         end
      end
   end

   // byte position inside the head frame
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         byte_idx_reg <= 3'h0;
      end else if (clk_en) begin
         if (clr_queue | pop | drop_old | gap_discard) begin
            byte_idx_reg <= 3'h0;
         end else if (data_read & has_data) begin
            byte_idx_reg <= byte_idx_reg + 3'h1;
         end
      end
   end

   // overrun survives draining; only a configuration or threshold write clears it
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         overrun_reg <= 1'b0;
      end else if (clk_en) begin
         if (clr_queue) begin
            overrun_reg <= 1'b0;
         end else if (sample_valid & is_full & ~pop) begin
            overrun_reg <= 1'b1;
         end
      end
   end

   // full and threshold events
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         full_evt_reg <= 1'b0;
         thr_evt_reg  <= 1'b0;
      end else if (clk_en) begin
         if (clr_queue) begin
            full_evt_reg <= 1'b0;
            thr_evt_reg  <= 1'b0;
         end else if (push) begin
            if (level_reg + 7'h01 >= depth) begin
               full_evt_reg <= 1'b1;
            end
            if (~is_full & (level_reg + 7'h01 == {1'b0, thresh_reg})) begin
               thr_evt_reg <= 1'b1;
            end
         end
      end
   end

   always @(posedge clk_sys) begin
      if (clk_en & push) begin
         mem[wr_ptr_reg] <= {accel_z, accel_y, accel_x};
      end
   end
endmodule // accel_frame_queue

/* testbench/afq_checker.sv */
// checker: bus answers and second interrupt pin of the frame queue
// assumes it is bound to accel_frame_queue; one clock domain
`timescale 1ns/1ps
module afq_checker (
   input wire        clk_sys, reset_n, s_axi_awvalid, s_axi_awready,
   input wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire        s_axi_rvalid, s_axi_rready, second_irq_pin,
   input wire [1:0]  s_axi_bresp, s_axi_rresp,
   input wire [31:0] s_axi_awaddr, s_axi_araddr, s_axi_rdata
);
   reg        map_seen_reg;
   wire       ar_take = s_axi_arvalid && s_axi_arready;
   wire [5:0] ar_idx  = s_axi_araddr[7:2];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // the pin cannot rise before the pin map register was written
   always @(posedge clk_sys or negedge reset_n)
      if (!reset_n)
         map_seen_reg <= 1'b0;
      else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] == 6'h1A)
         map_seen_reg <= 1'b1;
   AST_RD_ANSWER: assert property (ar_take |=> s_axi_rvalid)
      else $error("read answer missing");
   AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   AST_RD_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
      else $error("write answer missing");
   AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   AST_RESTART_ZERO: assert property (ar_take && ar_idx == 6'h14 |=> s_axi_rdata == 32'h0)
      else $error("restart register not zero");
   AST_LEVEL_MAX: assert property (ar_take && ar_idx == 6'h0E |=> s_axi_rdata[6:0] <= 7'h20)
      else $error("level above 32");
   AST_POLICY_CODE: assert property (ar_take && ar_idx == 6'h3E |=> s_axi_rdata[7:6] != 2'h3)
      else $error("bad policy code");
   AST_PIN_MAP: assert property (second_irq_pin |-> map_seen_reg)
      else $error("pin without map");
   AST_RESP_OKAY: assert property (s_axi_bvalid || s_axi_rvalid
      |-> s_axi_bresp == 2'h0 && s_axi_rresp == 2'h0) else $error("bus response not okay");
   cover property ($rose(second_irq_pin));
   cover property (ar_take && ar_idx == 6'h3F);
   cover property (s_axi_bvalid && s_axi_bready);
endmodule // afq_checker
bind accel_frame_queue afq_checker chk_i (.*);

/* testbench/host_model.sv */
// host model: register bus master and end-of-access marker
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module host_model (
   input  wire        clk_sys, s_axi_awready, s_axi_wready, s_axi_bvalid,
   input  wire        s_axi_arready, s_axi_rvalid,
   input  wire [31:0] s_axi_rdata,
   output reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr,
   output reg  [3:0]  s_axi_wstrb,
   output reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
   output reg         s_axi_rready, frame_gap
);
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      {s_axi_wstrb, frame_gap} = 5'h1E;
   end
   task automatic wr(input [5:0] i, input [7:0] d);
      reg a, w, b;
      @(posedge clk_sys);
      {s_axi_awaddr, s_axi_wdata} <= {24'h000000, i, 2'b00, 24'h000000, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(negedge clk_sys);
         a = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         @(posedge clk_sys);
         if (a) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!b);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input [5:0] i, output [7:0] d);
      reg a, b;
      @(posedge clk_sys);
      s_axi_araddr <= {24'h000000, i, 2'b00};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(negedge clk_sys);
         a = s_axi_arvalid && s_axi_arready;
         b = s_axi_rvalid;
         d = s_axi_rdata[7:0];
         @(posedge clk_sys);
         if (a) s_axi_arvalid <= 1'b0;
      end while (!b);
      s_axi_rready <= 1'b0;
   endtask
   // end of access; 300 cycles cover the gap before the next queue read
   task gap;
      @(posedge clk_sys);
      frame_gap <= 1'b1;
      repeat (300) @(posedge clk_sys);
      frame_gap <= 1'b0;
   endtask
endmodule // host_model

/* testbench/accel_frame_queue_tb.sv */
// testbench for the frame queue: registers, queue policies and events
// assumes host_model as bus master and afq_checker bound to the design
`timescale 1ns/1ps
module accel_frame_queue_tb;
   reg         clk_sys, reset_n, clk_en, sample_valid, restart_seen;
   reg  [15:0] accel_x, accel_y, accel_z;
   reg  [7:0]  d;
   integer     errors, total_checks, cycles, k;
   wire [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   wire [3:0]  s_axi_wstrb;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   wire        s_axi_rvalid, s_axi_rready, frame_gap, second_irq_pin, soft_restart_pulse;
   accel_frame_queue DUT (.*);
   host_model host (.*);
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (soft_restart_pulse === 1'b1) restart_seen = 1'b1;
      if (cycles == 10000) begin
         errors = errors + 1;
         finish_test;
      end
   end
   task chk(input [7:0] got, input [7:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) errors = errors + 1;
      if (got !== exp) $display("mismatch at %0t: got %h expected %h", $time, got, exp);
   endtask
   task rc(input [5:0] i, input [7:0] e);
      host.rd(i, d);
      chk(d, e);
   endtask
   task push(input [7:0] i);
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      {accel_x, accel_y, accel_z} <= {8'h11, i, 8'h22, i, 8'h33, i};
      @(posedge clk_sys);
      sample_valid <= 1'b0;
   endtask
   task rf(input [7:0] i);
      integer j;
      for (j = 1; j < 4; j = j + 1) begin
         rc(6'h3F, i);
         rc(6'h3F, 8'(8'h11 * j));
      end
   endtask
   task t_regs;
      rc(6'h14, 8'h00);
      rc(6'h3C, 8'h00);
      host.wr(6'h0E, 8'h7F);
      rc(6'h0E, 8'h00);
      for (k = 0; k < 3; k = k + 1) begin
         host.wr(6'h3E, {k[1:0], 6'h00});
         rc(6'h3E, {k[1:0], 6'h00});
      end
      host.wr(6'h14, 8'hB6);
      repeat (2) @(negedge clk_sys);
      chk({7'h00, restart_seen}, 8'h01);
      $display("regs done");
   endtask
   task t_stop;
      host.wr(6'h3E, 8'h40);
      for (k = 0; k < 31; k = k + 1) push(k[7:0]);
      rc(6'h0A, 8'h00);
      push(8'h1F);
      rc(6'h0A, 8'h20);
      push(8'h20);
      rc(6'h0E, 8'hA0);
      rc(6'h02, 8'h20);
      rf(8'h00);
      rc(6'h0E, 8'h9F);
      $display("stop done");
   endtask
   task t_stream;
      host.wr(6'h17, 8'h20);
      host.wr(6'h1A, 8'h20);
      host.wr(6'h3E, 8'h80);
      for (k = 0; k < 32; k = k + 1) push(k[7:0]);
      rc(6'h0E, 8'h9F);
      chk({7'h00, second_irq_pin}, 8'h01);
      rf(8'h01);
      host.wr(6'h3E, 8'h80);
      rc(6'h0A, 8'h00);
      chk({7'h00, second_irq_pin}, 8'h00);
      rc(6'h0E, 8'h00);
      $display("stream done");
   endtask
   task t_single;
      host.wr(6'h3E, 8'h00);
      push(8'h05);
      push(8'h06);
      rc(6'h0E, 8'h81);
      rc(6'h0A, 8'h20);
      chk({7'h00, second_irq_pin}, 8'h01);
      rc(6'h3F, 8'h06);
      host.gap;
      rc(6'h0E, 8'h80);
      rc(6'h3F, 8'h00);
      $display("single done");
   endtask
   task t_thresh;
      host.wr(6'h17, 8'h40);
      host.wr(6'h1A, 8'h40);
      host.wr(6'h3E, 8'h41);
      host.wr(6'h30, 8'h03);
      push(8'h07);
      push(8'h08);
      rc(6'h0A, 8'h00);
      push(8'h09);
      rc(6'h0A, 8'h40);
      chk({7'h00, second_irq_pin}, 8'h01);
      rc(6'h3F, 8'h07);
      rc(6'h3F, 8'h11);
      rc(6'h0E, 8'h02);
      host.wr(6'h3E, 8'h42);
      push(8'h0A);
      rc(6'h3F, 8'h0A);
      rc(6'h3F, 8'h22);
      rc(6'h0E, 8'h00);
      $display("threshold done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      errors = 0;
      total_checks = 0;
      cycles = 0;
      {reset_n, clk_en, sample_valid, restart_seen} = 4'h4;
      {accel_x, accel_y, accel_z} = 48'h0;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_regs;
      t_stop;
      t_stream;
      t_single;
      t_thresh;
      finish_test;
   end
endmodule // accel_frame_queue_tb
